/* File: ipo_pkg.sv */
/*
 Constants, register map and encodings for the privileged register
 ordering block. Assumes one core clock and an APB register port.
*/
package ipo_pkg;
   localparam int          XLEN           = 64;
   localparam int          SB_W           = 8;
   localparam int          FPX_W          = 6;
   localparam int          SHD_N          = 8;
   // Instruction kinds presented at the map stage.
   localparam logic [2:0]  K_OTHER        = 3'h0;
   localparam logic [2:0]  K_MEM          = 3'h1;
   localparam logic [2:0]  K_IPR_WR       = 3'h2;
   localparam logic [2:0]  K_IPR_RD       = 3'h3;
   localparam logic [2:0]  K_RET          = 3'h4;
   localparam logic [2:0]  K_RET_STALL    = 3'h5;
   // APB byte addresses.
   localparam logic [7:0]  A_CTRL         = 8'h00;
   localparam logic [7:0]  A_BASE_LO      = 8'h04;
   localparam logic [7:0]  A_BASE_HI      = 8'h08;
   localparam logic [7:0]  A_SB_STAT      = 8'h0C;
   localparam logic [7:0]  A_FPC_LO       = 8'h10;
   localparam logic [7:0]  A_FPC_HI       = 8'h14;
   localparam logic [7:0]  A_EXC_SUM      = 8'h18;
   localparam logic [7:0]  A_STALL        = 8'h1C;
   localparam int          SHADOW_EN_BIT  = 1;
   localparam int          BASE_LSB       = 15;
   localparam int          FPC_ST_LSB     = 52;
   localparam int          FPC_EN_LSB     = 0;
   // Entry offsets above the firmware base.
   localparam logic [14:0] VEC_ARITHMETIC_TRAP_HANDLER      = 15'h0600;
   localparam logic [14:0] VEC_FPW        = 15'h0700;
   localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
   localparam logic [63:0] RST_BASE       = 64'h0000_0000_0000_0000;
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_HOLD = 2'b10
   } ipo_stall_e;
endpackage

/* File: ipo_ctrl.sv */
/*
 Privileged register ordering: scoreboard, stall-flagged return hold,
 issue gating, shadow registers, two-stage FP control register and trap
 vectoring. Assumes the pipeline presents one map-stage instruction at a
 time and reports issue, retire and abort events synchronously to pclk.
*/
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ipo_ctrl
   import ipo_pkg::*;
(
   // Clock and reset.
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave.
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Map stage.
   input  wire logic               map_valid,
   input  wire logic               map_new_block,
   input  wire logic [2:0]         map_kind,
   input  wire logic [2:0]         map_group,
   output logic                    map_ready,
   // Writer issue, retire and abort events.
   input  wire logic               wr_issue,
   input  wire logic [2:0]         wr_issue_group,
   input  wire logic               wr_retire,
   input  wire logic [2:0]         wr_retire_group,
   input  wire logic               pipe_abort,
   // Stall-flagged return completion and pipeline hold.
   input  wire logic               ret_done,
   output logic                    fetch_hold,
   // Issue gating.
   input  wire logic               ipr_issue_req,
   input  wire logic               load_issue_req,
   input  wire logic               store_bubble_busy,
   input  wire logic               load_bubble_busy,
   output logic                    ipr_issue_grant,
   output logic                    load_issue_grant,
   // Privileged mode and shadow register access.
   input  wire logic               priv_mode,
   input  wire logic               rf_wr_en,
   input  wire logic [4:0]         rf_wr_addr,
   input  wire logic [XLEN-1:0]    rf_wr_data,
   input  wire logic [4:0]         rf_rd_addr,
   output logic                    shadow_hit,
   output logic      [XLEN-1:0]    shadow_rd_data,
   input  wire logic               call_valid,
   input  wire logic [XLEN-1:0]    call_ret_pc,
   // FP control register and exceptions.
   input  wire logic               fpw_exec,
   input  wire logic [XLEN-1:0]    fpw_data,
   input  wire logic               fpw_retire,
   output logic      [XLEN-1:0]    fp_rd_data,
   input  wire logic               fp_exc_valid,
   input  wire logic [FPX_W-1:0]   fp_exc_flags,
   // Firmware trap request.
   output logic                    trap_valid,
   output logic      [XLEN-1:0]    trap_pc
);

////////////////////////////////////////////////////////////////////////////////
// Register bus.

   logic                 shadow_en;
   logic [XLEN-1:0]      fw_base;
   logic [SB_W-1:0]      sb;
   logic [SB_W-1:0]      pend;
   logic [XLEN-1:0]      fpc_first;
   logic [XLEN-1:0]      fpc_second;
   logic [FPX_W-1:0]     exc_sum;
   ipo_stall_e           stall_state;
   ipo_stall_e           next_stall_state;

   wire        bus_wr     = psel & penable & pwrite;
   wire        hit_ctrl   = (paddr == A_CTRL);
   wire        hit_blo    = (paddr == A_BASE_LO);
   wire        hit_bhi    = (paddr == A_BASE_HI);
   wire        hit_sb     = (paddr == A_SB_STAT);
   wire        hit_flo    = (paddr == A_FPC_LO);
   wire        hit_fhi    = (paddr == A_FPC_HI);
   wire        hit_exc    = (paddr == A_EXC_SUM);
   wire        hit_stall  = (paddr == A_STALL);
   wire        hit_any    = hit_ctrl | hit_blo | hit_bhi | hit_sb | hit_flo |
                            hit_fhi | hit_exc | hit_stall;
   wire        stall_on   = (stall_state == ST_HOLD);
   wire [31:0] ctrl_word  = {30'h0000_0000, shadow_en, 1'b0};
   wire [31:0] rd_mux     = hit_ctrl  ? ctrl_word :
                            hit_blo   ? fw_base[31:0] :
                            hit_bhi   ? fw_base[63:32] :
                            hit_sb    ? {16'h0000, pend, sb} :
                            hit_flo   ? fpc_second[31:0] :
                            hit_fhi   ? fpc_second[63:32] :
                            hit_exc   ? {26'h000_0000, exc_sum} :
                            hit_stall ? {31'h0000_0000, stall_on} :
                                        32'h0000_0000;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = (psel & ~pwrite) ? rd_mux : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_en <= RST_CTRL[SHADOW_EN_BIT];
         fw_base   <= RST_BASE;
      end else if (bus_wr) begin
         if (hit_ctrl) begin
            shadow_en <= pwdata[SHADOW_EN_BIT];
         end
         if (hit_blo) begin
            fw_base[31:0] <= {pwdata[31:BASE_LSB], 15'h0000};
         end
         if (hit_bhi) begin
            fw_base[63:32] <= pwdata;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Scoreboard and map-stage hold.

   wire [SB_W-1:0] grp_bit  = SB_W'(1) << map_group;
   wire [SB_W-1:0] iss_clr  = wr_issue ? (SB_W'(1) << wr_issue_group) &
                                         8'h0F : 8'h00;
   wire [SB_W-1:0] ret_clr  = wr_retire ? (SB_W'(1) << wr_retire_group) &
                                          8'hF0 : 8'h00;
   wire [SB_W-1:0] clr_mask = pipe_abort ? 8'hFF : (iss_clr | ret_clr);
   // Writers of the current fetch block only become visible to the next.
   wire [SB_W-1:0] sb_view  = map_new_block ? (sb | pend) : sb;
   wire is_mem   = (map_kind == K_MEM);
   wire is_ipr   = (map_kind == K_IPR_WR) | (map_kind == K_IPR_RD);
   wire mem_blk  = is_mem & (|sb_view[3:0]);
   wire ipr_blk  = is_ipr & (|(sb_view & grp_bit));
   wire map_hold = stall_on | mem_blk | ipr_blk;
   wire map_acc  = map_valid & ~map_hold;
   wire wr_acc   = map_acc & (map_kind == K_IPR_WR);
   wire ret_stall_acc = map_acc & (map_kind == K_RET_STALL);
   wire [SB_W-1:0] set_mask = wr_acc ? grp_bit : 8'h00;

   assign map_ready  = ~map_hold;
   assign fetch_hold = stall_on;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sb   <= 8'h00;
         pend <= 8'h00;
      end else if (map_acc & map_new_block) begin
         sb   <= (sb | pend) & ~clr_mask;
         pend <= set_mask;
      end else begin
         sb   <= sb & ~clr_mask;
         pend <= (pend & ~clr_mask) | set_mask;
      end
   end

   always_comb begin
      next_stall_state = stall_state;
      case (stall_state)
         ST_RUN:  if (ret_stall_acc) next_stall_state = ST_HOLD;
         ST_HOLD: if (ret_done) next_stall_state = ST_RUN;
         default: next_stall_state = ST_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_state <= ST_RUN;
      end else begin
         stall_state <= next_stall_state;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Issue gating.

   assign ipr_issue_grant  = ipr_issue_req & ~store_bubble_busy &
                             ~stall_on;
   assign load_issue_grant = load_issue_req & ~load_bubble_busy &
                             ~stall_on;

////////////////////////////////////////////////////////////////////////////////
// Shadow registers.

   logic [XLEN-1:0] shadow [SHD_N];

   function automatic logic [3:0] shd_index(input logic [4:0] r);
      logic [3:0] idx;
      idx = 4'h8;
      if (r >= 5'd4 && r <= 5'd7) begin
         idx = {2'b00, r[1:0]};
      end else if (r >= 5'd20 && r <= 5'd23) begin
         idx = {2'b01, r[1:0]};
      end
      return idx;
   endfunction

   wire             overlay_on = priv_mode & shadow_en;
   wire [3:0]       wr_idx     = shd_index(rf_wr_addr);
   wire [3:0]       rd_idx     = shd_index(rf_rd_addr);
   wire [XLEN-1:0]  call_link  = {call_ret_pc[XLEN-1:1], priv_mode};

   for (genvar g = 0; g < SHD_N; g++) begin : g_shadow
      wire rf_hit = overlay_on & rf_wr_en & (wr_idx == 4'(g));
      wire cl_hit = call_valid & (g == SHD_N - 1);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            shadow[g] <= 64'h0000_0000_0000_0000;
         end else if (cl_hit) begin
            shadow[g] <= call_link;
         end else if (rf_hit) begin
            shadow[g] <= rf_wr_data;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_hit     <= 1'b0;
         shadow_rd_data <= 64'h0000_0000_0000_0000;
      end else begin
         shadow_hit     <= overlay_on & ~rd_idx[3];
         shadow_rd_data <= rd_idx[3] ? 64'h0000_0000_0000_0000 :
                           shadow[rd_idx[2:0]];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// FP control register and firmware traps.

   wire [FPX_W-1:0] fp_status = fpc_second[FPC_ST_LSB +: FPX_W];
   wire [FPX_W-1:0] fp_enable = fpc_second[FPC_EN_LSB +: FPX_W];
   wire arithmetic_trap_handler_hit = fp_exc_valid &
                    (|(fp_exc_flags & (~fp_status | fp_enable)));
   wire [XLEN-1:0] fpw_vec   = {fw_base[XLEN-1:BASE_LSB], VEC_FPW};
   wire [XLEN-1:0] arithmetic_trap_handler_vec = {fw_base[XLEN-1:BASE_LSB], VEC_ARITHMETIC_TRAP_HANDLER};

   assign fp_rd_data = fpc_second;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fpc_first  <= 64'h0000_0000_0000_0000;
         fpc_second <= 64'h0000_0000_0000_0000;
      end else begin
         if (fpw_exec) begin
            fpc_first <= fpw_data;
         end
         if (fpw_retire) begin
            fpc_second <= fpc_first;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_valid <= 1'b0;
         trap_pc    <= 64'h0000_0000_0000_0000;
         exc_sum    <= 6'h00;
      end else begin
         trap_valid <= fpw_exec | arithmetic_trap_handler_hit;
         if (fpw_exec) begin
            trap_pc <= fpw_vec;
         end else if (arithmetic_trap_handler_hit) begin
            trap_pc <= arithmetic_trap_handler_vec;
         end
         if (arithmetic_trap_handler_hit) begin
            exc_sum <= fp_exc_flags;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Assertions.

   property p_mem_hold;
      @(posedge pclk) disable iff (!presetn)
      (map_valid && is_mem && (|sb[3:0])) |-> !map_ready;
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("memory op passed a set translation bit");

   property p_same_block;
      @(posedge pclk) disable iff (!presetn)
      (map_valid && !map_new_block && !stall_on && sb == 8'h00)
         |-> map_ready;
   endproperty
   a_same_block: assert property (p_same_block)
      else $error("stall inside one fetch block");

   property p_stall_hold;
      @(posedge pclk) disable iff (!presetn)
      stall_on |-> (fetch_hold && !map_ready && !ipr_issue_grant);
   endproperty
   a_stall_hold: assert property (p_stall_hold)
      else $error("pipeline moved during stall return");

   property p_stall_set;
      @(posedge pclk) disable iff (!presetn)
      ret_stall_acc |=> (fetch_hold throughout (!ret_done)[*1]);
   endproperty
   a_stall_set: assert property (p_stall_set)
      else $error("stall return did not hold fetch");

   property p_ipr_issue;
      @(posedge pclk) disable iff (!presetn)
      store_bubble_busy |-> !ipr_issue_grant;
   endproperty
   a_ipr_issue: assert property (p_ipr_issue)
      else $error("privileged op issued while store bubbles busy");

   property p_second;
      @(posedge pclk) disable iff (!presetn)
      (fpw_exec ##1 fpw_retire) |=> fp_rd_data == $past(fpw_data, 2);
   endproperty
   a_second: assert property (p_second)
      else $error("second latch missed retired value");

   property p_fpw_trap;
      @(posedge pclk) disable iff (!presetn)
      fpw_exec |=> (trap_valid && trap_pc == $past(fpw_vec));
   endproperty
   a_fpw_trap: assert property (p_fpw_trap)
      else $error("control write trap vector wrong");

   property p_arithmetic_trap_handler;
      @(posedge pclk) disable iff (!presetn)
      (arithmetic_trap_handler_hit && !fpw_exec) |=> (trap_valid && trap_pc == $past(arithmetic_trap_handler_vec));
   endproperty
   a_arithmetic_trap_handler: assert property (p_arithmetic_trap_handler)
      else $error("arithmetic trap missing");

   property p_call_link;
      @(posedge pclk) disable iff (!presetn)
      call_valid |=> shadow[SHD_N-1] == $past(call_link);
   endproperty
   a_call_link: assert property (p_call_link)
      else $error("call link not written to shadow");

   property p_shadow_off;
      @(posedge pclk) disable iff (!presetn)
      !overlay_on |=> !shadow_hit;
   endproperty
   a_shadow_off: assert property (p_shadow_off)
      else $error("shadow overlay outside shadow mode");

endmodule // ipo_ctrl
`default_nettype wire

/* File: ipo_fw.sv */
/*
 Firmware model that presents one instruction at a time at the map stage.
 Assumes the bench pulses go for one cycle and waits for busy to fall.
*/
`timescale 1ns/10ps
`default_nettype none
module ipo_fw
   import ipo_pkg::*;
(
   // Clock and bench requests.
   input  wire logic       pclk,
   input  wire logic       go,
   input  wire logic [2:0] kind,
   input  wire logic [2:0] grp,
   input  wire logic       nb,
   output logic            busy,
   // Map stage.
   output logic            map_valid,
   output logic            map_new_block,
   output logic [2:0]      map_kind,
   output logic [2:0]      map_group,
   input  wire logic       map_ready
);
   logic [7:0] blk_wr;
   wire        clash = (kind == K_IPR_WR || kind == K_IPR_RD) ? blk_wr[grp] :
                       (kind == K_MEM || kind == K_RET) ? |blk_wr[3:0] : 1'b0;
   initial begin
      {busy, map_valid, map_new_block, map_kind, map_group} = '0;
      blk_wr = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // Released lines flip so that no stale value looks valid.
   always @(posedge pclk) begin
      if (map_valid && map_ready) begin
         map_valid     <= 1'b0;
         busy          <= 1'b0;
         map_kind      <= ~map_kind;
         map_group     <= ~map_group;
         map_new_block <= ~map_new_block;
         blk_wr        <= (map_new_block ? 8'h00 : blk_wr) |
                          (map_kind == K_IPR_WR ? 8'h01 << map_group : 8'h00);
      end else if (go && !busy) begin
         map_valid     <= 1'b1;
         busy          <= 1'b1;
         map_kind      <= kind;
         map_group     <= grp;
         map_new_block <= nb | clash;
      end
   end
endmodule // ipo_fw
`default_nettype wire

/* File: ipo_tb.sv */
/*
 Self-checking bench for the privileged register ordering block.
 Assumes ipo_pkg, ipo_ctrl and the firmware model ipo_fw are compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
   import ipo_pkg::*;
;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic             map_valid, map_new_block, map_ready, go, nb, busy;
   logic [2:0]       map_kind, map_group, kind, grp;
   logic [2:0]       wr_issue_group, wr_retire_group;
   logic             wr_issue, wr_retire, pipe_abort, ret_done, fetch_hold;
   logic             ipr_issue_req, load_issue_req, store_bubble_busy;
   logic             load_bubble_busy, ipr_issue_grant, load_issue_grant;
   logic             priv_mode, rf_wr_en, shadow_hit, call_valid;
   logic [4:0]       rf_wr_addr, rf_rd_addr;
   logic [XLEN-1:0]  rf_wr_data, shadow_rd_data, call_ret_pc, fpw_data;
   logic [XLEN-1:0]  fp_rd_data, trap_pc, base, fpc, d;
   logic             fpw_exec, fpw_retire, fp_exc_valid, trap_valid;
   logic             err, en, pm, h;
   logic [FPX_W-1:0] fp_exc_flags, f;
   logic [3:0]       r;
   integer           seed = 52, error_cnt = 0, tests_run = 0, i, c, c2;

   ipo_ctrl uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .map_valid(map_valid),
      .map_new_block(map_new_block), .map_kind(map_kind),
      .map_group(map_group), .map_ready(map_ready), .wr_issue(wr_issue),
      .wr_issue_group(wr_issue_group), .wr_retire(wr_retire),
      .wr_retire_group(wr_retire_group), .pipe_abort(pipe_abort),
      .ret_done(ret_done), .fetch_hold(fetch_hold),
      .ipr_issue_req(ipr_issue_req), .load_issue_req(load_issue_req),
      .store_bubble_busy(store_bubble_busy),
      .load_bubble_busy(load_bubble_busy),
      .ipr_issue_grant(ipr_issue_grant),
      .load_issue_grant(load_issue_grant), .priv_mode(priv_mode),
      .rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data),
      .rf_rd_addr(rf_rd_addr), .shadow_hit(shadow_hit),
      .shadow_rd_data(shadow_rd_data), .call_valid(call_valid),
      .call_ret_pc(call_ret_pc), .fpw_exec(fpw_exec), .fpw_data(fpw_data),
      .fpw_retire(fpw_retire), .fp_rd_data(fp_rd_data),
      .fp_exc_valid(fp_exc_valid), .fp_exc_flags(fp_exc_flags),
      .trap_valid(trap_valid), .trap_pc(trap_pc)
   );
   ipo_fw fw (
      .pclk(pclk), .go(go), .kind(kind), .grp(grp), .nb(nb), .busy(busy),
      .map_valid(map_valid), .map_new_block(map_new_block),
      .map_kind(map_kind), .map_group(map_group), .map_ready(map_ready)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic fw_go(input logic [2:0] k, input logic [2:0] g,
                        input logic n);
      @(posedge pclk);
      {go, kind, grp, nb} <= {1'b1, k, g, n};
      @(posedge pclk);
      go <= 1'b0;
   endtask
   task automatic fw_wait;
      c = 0;
      do begin
         @(negedge pclk);
         c++;
      end while (busy !== 1'b0 && c < 30);
      chk(busy, 0);
   endtask
   task automatic sb_case(input logic [2:0] g, input logic [2:0] k,
                          input int m);
      fw_go(K_IPR_WR, g, 1'b1);
      fw_wait;
      fw_go(K_OTHER, 3'h0, 1'b0);
      fw_wait;
      fw_go(k, g, 1'b1);
      repeat (3) @(negedge pclk);
      chk(map_ready, 0);
      @(posedge pclk);
      {wr_issue, wr_retire, pipe_abort} <= {m == 0, m == 1, m == 2};
      {wr_issue_group, wr_retire_group} <= {g, g};
      @(posedge pclk);
      {wr_issue, wr_retire, pipe_abort} <= 3'h0;
      fw_wait;
   endtask
   task automatic fpw(input logic [63:0] v);
      @(posedge pclk);
      {fpw_exec, fpw_data} <= {1'b1, v};
      @(posedge pclk);
      fpw_exec <= 1'b0;
      @(negedge pclk);
      chk(trap_valid, 1);
      chk(trap_pc, {base[63:15], VEC_FPW});
      chk(fp_rd_data, fpc);
      @(posedge pclk);
      fpw_retire <= 1'b1;
      @(posedge pclk);
      fpw_retire <= 1'b0;
      fpc = v;
      @(negedge pclk);
      chk(fp_rd_data, fpc);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      give_verdict;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, go, kind, grp, nb} = '0;
      {wr_issue, wr_issue_group, wr_retire, wr_retire_group, pipe_abort} = '0;
      {ret_done, ipr_issue_req, load_issue_req, store_bubble_busy} = '0;
      {load_bubble_busy, priv_mode, rf_wr_en, rf_wr_addr, rf_rd_addr} = '0;
      {rf_wr_data, call_valid, call_ret_pc, fpw_exec, fpw_data} = '0;
      {fpw_retire, fp_exc_valid, fp_exc_flags} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, A_CTRL, 32'h0000_0002);
      apb(1'b0, A_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      d = {$random(seed), $random(seed)};
      apb(1'b1, A_BASE_LO, d[31:0]);
      apb(1'b1, A_BASE_HI, d[63:32]);
      base = {d[63:15], 15'h0000};
      apb(1'b0, A_BASE_LO, 32'h0000_0000);
      chk(rd, base[31:0]);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({err, rd}, {1'b1, 32'h0000_0000});
      $display("test register access done");
      sb_case(3'h0, K_MEM, 0);
      sb_case(3'h4, K_IPR_RD, 1);
      sb_case(3'h2, K_MEM, 2);
      for (i = 0; i < 5; i++) begin
         fw_go((i < 2) ? K_IPR_WR : K_OTHER, 3'h5, 1'b1);
         if (i == 1) begin
            repeat (3) @(negedge pclk);
            chk(map_ready, 0);
            @(posedge pclk);
            {wr_retire, wr_retire_group} <= {1'b1, 3'h5};
            @(posedge pclk);
            wr_retire <= 1'b0;
         end
         fw_wait;
      end
      apb(1'b0, A_SB_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0020);
      @(posedge pclk);
      {wr_retire, wr_retire_group} <= {1'b1, 3'h5};
      @(posedge pclk);
      wr_retire <= 1'b0;
      $display("test scoreboard done");
      for (i = 0; i < 32; i++) begin
         @(posedge pclk);
         r = 4'($random(seed));
         {ipr_issue_req, load_issue_req, store_bubble_busy,
          load_bubble_busy} <= r;
         @(negedge pclk);
         chk(ipr_issue_grant, r[3] & ~r[1]);
         chk(load_issue_grant, r[2] & ~r[0]);
      end
      @(posedge pclk);
      {ipr_issue_req, load_issue_req, store_bubble_busy,
       load_bubble_busy} <= 4'b1010;
      @(negedge pclk);
      chk(ipr_issue_grant, 0);
      @(posedge pclk);
      store_bubble_busy <= 1'b0;
      @(negedge pclk);
      chk(ipr_issue_grant, 1);
      @(posedge pclk);
      load_issue_req <= 1'b1;
      @(negedge pclk);
      chk(load_issue_grant, 1);
      $display("test issue gating done");
      fw_go(K_RET_STALL, 3'h0, 1'b1);
      fw_wait;
      chk(fetch_hold, 1);
      apb(1'b0, A_STALL, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      @(posedge pclk);
      {ipr_issue_req, load_issue_req, store_bubble_busy} <= 3'b110;
      load_bubble_busy <= 1'b0;
      fw_go(K_OTHER, 3'h0, 1'b1);
      repeat (3) @(negedge pclk);
      chk({map_ready, ipr_issue_grant, load_issue_grant}, 0);
      @(posedge pclk);
      ret_done <= 1'b1;
      @(posedge pclk);
      ret_done <= 1'b0;
      fw_wait;
      chk(fetch_hold, 0);
      $display("test stall return done");
      for (c2 = 0; c2 < 3; c2++) begin
         en = (c2 != 1);
         pm = (c2 != 2);
         apb(1'b1, A_CTRL, {30'h0000_0000, en, 1'b0});
         for (i = 2; i < 26; i++) begin
            d = {$random(seed), $random(seed)};
            @(posedge pclk);
            {priv_mode, rf_wr_en, rf_wr_addr, rf_wr_data} <= {pm, 1'b1,
                                                              i[4:0], d};
            @(posedge pclk);
            {rf_wr_en, rf_rd_addr} <= {1'b0, i[4:0]};
            @(posedge pclk);
            @(negedge pclk);
            h = en & pm & (i inside {[4:7], [20:23]});
            chk(shadow_hit, h);
            if (h)
               chk(shadow_rd_data, d);
         end
      end
      apb(1'b1, A_CTRL, 32'h0000_0002);
      d = {$random(seed), $random(seed)};
      {priv_mode, call_valid, call_ret_pc, rf_rd_addr} <= {2'b11, d, 5'd23};
      @(posedge pclk);
      call_valid <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk(shadow_rd_data, {d[63:1], 1'b1});
      $display("test shadow done");
      fpc = 64'h0000_0000_0000_0000;
      for (i = 0; i < 8; i++) begin
         d = {$random(seed), $random(seed)};
         if (i[0])
            d = (d | 64'h03F0_0000_0000_0000) & ~64'h0000_0000_0000_003F;
         fpw(d);
         f = 6'($random(seed)) | 6'h01;
         @(posedge pclk);
         {fp_exc_valid, fp_exc_flags} <= {1'b1, f};
         @(posedge pclk);
         fp_exc_valid <= 1'b0;
         @(negedge pclk);
         h = |(f & (~fpc[FPC_ST_LSB +: FPX_W] | fpc[FPC_EN_LSB +: FPX_W]));
         chk(trap_valid, h);
         if (h) begin
            chk(trap_pc, {base[63:15], VEC_ARITHMETIC_TRAP_HANDLER});
            apb(1'b0, A_EXC_SUM, 32'h0000_0000);
            chk(rd, {26'h000_0000, f});
            fpw(fpc | (64'(f) << FPC_ST_LSB));
         end
      end
      $display("test fp control done");
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
